// ===== hdl/rsris_top.sv
// Purpose: Reset sources, sleep and limp home control, channel selection
// Assumes: Supply-good comparators and limp input synchronous to sys_clk
// Notes:   Diagnosis bits are latched from an external detector input
`default_nettype none
module rsris_top
  import rsris_pkg::*;
#(
  parameter int NCH      = NUM_CHANNELS,
  parameter int UV_CYC   = UV_DELAY_CYC,
  parameter int WAKE_CNT = WAKE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              vbb_good,
  input  wire logic              vdd_good,
  input  wire logic              limp_home_input,
  input  wire logic              input_pin_one,
  input  wire logic              input_pin_two,
  input  wire rsris_cmd_req_type cmd,
  input  wire logic              frame_read,
  input  wire logic [7:0]        diag_events,
  output logic [NCH-1:0]         channel_on,
  output logic [2*NCH-1:0]       channel_input_select,
  output rsris_frame_type        frame,
  output logic                   device_ready
);
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN, ST_SLEEP, ST_WAKING, ST_LIMP
  } rsris_mode_type;

  rsris_mode_type   mode;
  rsris_mode_type   next_mode;
  logic [15:0]      sel;
  logic [15:0]      next_sel;
  logic [7:0]       diag;
  logic [7:0]       next_diag;
  logic             error_flag;
  logic             next_error_flag;
  logic             uv_reset;
  logic             next_uv_reset;
  logic [31:0]      uv_cnt;
  logic [31:0]      next_uv_cnt;
  logic [31:0]      wake_cnt;
  logic [31:0]      next_wake_cnt;
  logic [NCH-1:0]   next_channel_on;
  logic [NCH-1:0]   drive;
  logic             supplies_ok;
  logic             any_reset;
  logic             cmd_ok;

  assign supplies_ok = vbb_good && vdd_good;

  // ---------------------------------------------------------------------
  // Undervoltage reset: asserted within the delay, held until good
  // ---------------------------------------------------------------------
  // Counter only guards the assert bound; release waits on supplies_ok
  always_comb begin
    next_uv_reset = uv_reset;
    next_uv_cnt   = 32'h0000_0000;
    if (supplies_ok) begin
      next_uv_reset = 1'b0;                                   // R4
    end else if (!uv_reset) begin
      next_uv_cnt = uv_cnt + 32'h0000_0001;
      if (uv_cnt + 32'h0000_0001 >= 32'(UV_CYC)) begin
        next_uv_reset = 1'b1;                                 // R5
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_reset <= 1'b1;
      uv_cnt   <= 32'h0000_0000;
    end else begin
      uv_reset <= next_uv_reset;
      uv_cnt   <= next_uv_cnt;
    end
  end

  // Commands are refused in limp home and under undervoltage reset; asleep, only selector writes are refused
  assign cmd_ok = cmd.valid && !uv_reset && mode != ST_LIMP;   // R10

  // Reset sources that clear the banks this cycle
  assign any_reset = uv_reset
                  || (cmd_ok && cmd.reset_bit)                 // R6
                  || (limp_home_input && mode != ST_LIMP);     // R8

  // ---------------------------------------------------------------------
  // Mode control: sleep, wake and limp home
  // ---------------------------------------------------------------------
  always_comb begin
    next_mode     = mode;
    next_wake_cnt = wake_cnt;
    case (mode)
      ST_RUN: begin
        if (limp_home_input) begin
          next_mode = ST_LIMP;                                 // R14
        end else if (cmd_ok && cmd.op == CMD_SLEEP) begin
          next_mode = ST_SLEEP;                                // R16
        end
      end
      ST_SLEEP: begin
        if (limp_home_input) begin
          next_mode = ST_LIMP;                                 // R14
        end else if (cmd.valid && !uv_reset && cmd.op == CMD_WAKE) begin
          next_mode     = ST_WAKING;                           // R16
          next_wake_cnt = 32'h0000_0000;
        end
      end
      ST_WAKING: begin
        next_wake_cnt = wake_cnt + 32'h0000_0001;
        if (limp_home_input) begin
          next_mode = ST_LIMP;
        end else if (wake_cnt + 32'h0000_0001 >= 32'(WAKE_CNT)) begin
          next_mode = ST_RUN;                                  // R13
        end
      end
      ST_LIMP: begin
        if (!limp_home_input) begin
          next_mode = ST_SLEEP;                                // R15
        end
      end
      default: next_mode = ST_SLEEP;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode     <= ST_RUN;
      wake_cnt <= 32'h0000_0000;
    end else begin
      mode     <= next_mode;
      wake_cnt <= next_wake_cnt;
    end
  end

  // ---------------------------------------------------------------------
  // Register banks: selectors, diagnosis and transmission error flag
  // ---------------------------------------------------------------------
  // Reset outranks a write in the same cycle so defaults always win
  always_comb begin
    next_sel        = sel;
    next_diag       = diag | diag_events;
    next_error_flag = error_flag;
    if (frame_read) begin
      next_error_flag = 1'b0;                                  // R19
      next_diag       = diag_events;
    end
    if (any_reset || (cmd_ok && cmd.op == CMD_SLEEP)) begin
      next_sel        = SEL_RESET;                             // R1 R7
      next_diag       = DIAG_RESET;                            // R7
      next_error_flag = 1'b1;                                  // R2
    end else if (cmd_ok && mode == ST_RUN && cmd.op == CMD_WRITE_SEL) begin
      next_sel = cmd.sel;
    end
    // Undervoltage keeps the flag up even if a frame is read
    if (uv_reset) begin
      next_error_flag = 1'b1;                                  // R3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel        <= SEL_RESET;
      diag       <= DIAG_RESET;
      error_flag <= 1'b1;
    end else begin
      sel        <= next_sel;
      diag       <= next_diag;
      error_flag <= next_error_flag;
    end
  end

  // ---------------------------------------------------------------------
  // Channel multiplexers
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      rsris_chan_mux u_mux (
        .sel     (sel[2*gi +: 2]),
        .pin_one (input_pin_one),
        .pin_two (input_pin_two),
        .drive   (drive[gi])
      );
    end
  endgenerate

  // Limp home routes pins straight to channels four and five
  always_comb begin
    next_channel_on = drive;
    if (mode == ST_LIMP) begin
      next_channel_on            = '0;
      next_channel_on[LIMP_CH_A] = input_pin_one;              // R14
      next_channel_on[LIMP_CH_B] = input_pin_two;              // R14
    end
    if (any_reset || mode == ST_SLEEP || mode == ST_WAKING) begin
      next_channel_on = '0;                                    // R1
    end
  end

  // ---------------------------------------------------------------------
  // Output registers and status frame
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_on           <= '0;
      channel_input_select <= '0;
      frame                <= '0;
      device_ready         <= 1'b0;
    end else begin
      channel_on           <= next_channel_on;
      channel_input_select <= 16'(next_sel);
      // Reads stay served in limp home with the limp bit shown
      frame.error_flag     <= next_error_flag;                 // R9
      frame.limp           <= (next_mode == ST_LIMP);          // R9
      frame.sleep          <= (next_mode == ST_SLEEP);
      frame.uv_reset       <= next_uv_reset;                   // R3
      frame.diag           <= next_diag;
      device_ready         <= (next_mode == ST_RUN) && !next_uv_reset;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // One cycle past the counter, since the raised reset is seen a cycle late
  localparam int UV_LIM = UV_CYC + 1;
  // Sampled rst term stops the release edge judging reset-time frame values
  a_uv_frame_err: assert property ( // R3
    @(posedge sys_clk) disable iff (rst)
    (uv_reset && !rst) |=> frame.error_flag)
    else $error("error flag low during undervoltage");
  a_uv_assert_bound: assert property ( // R5
    @(posedge sys_clk) disable iff (rst)
    $fell(supplies_ok) |-> ##[0:UV_LIM] (uv_reset || supplies_ok))
    else $error("undervoltage reset late");
  a_uv_hold: assert property ( // R4
    @(posedge sys_clk) disable iff (rst)
    (uv_reset && !supplies_ok) |=> uv_reset)
    else $error("undervoltage reset released early");
  a_uv_chan_off: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    uv_reset |=> channel_on == '0)
    else $error("channels on during undervoltage");
  a_uv_not_ready: assert property ( // R4
    @(posedge sys_clk) disable iff (rst)
    (uv_reset && !supplies_ok) |=> !device_ready)
    else $error("ready shown during undervoltage");
  a_reset_chan_off: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    any_reset |=> channel_on == '0 && sel == SEL_RESET)
    else $error("channels not off after reset");
  a_reset_sets_err: assert property ( // R2
    @(posedge sys_clk) disable iff (rst)
    any_reset |=> error_flag)
    else $error("error flag not set after reset");
  a_cmd_reset_diag: assert property ( // R7
    @(posedge sys_clk) disable iff (rst)
    (cmd_ok && cmd.reset_bit) |=> diag == DIAG_RESET)
    else $error("diagnosis not cleared by reset command");
  a_sel_write: assert property ( // R11
    @(posedge sys_clk) disable iff (rst)
    (cmd_ok && !any_reset && mode == ST_RUN && cmd.op == CMD_WRITE_SEL)
      |=> channel_input_select == $past(cmd.sel))
    else $error("selector write not taken");
  a_limp_no_write: assert property ( // R10
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP) |=> $stable(sel))
    else $error("selector changed in limp home");
  a_limp_exit_sleep: assert property ( // R15
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP && !limp_home_input) |=> mode == ST_SLEEP)
    else $error("limp exit did not sleep");
  a_limp_route: assert property ( // R14
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP && limp_home_input && !uv_reset)
      |=> channel_on[LIMP_CH_A] == $past(input_pin_one))
    else $error("limp routing wrong");
  a_limp_route_b: assert property ( // R14
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP && limp_home_input && !uv_reset)
      |=> channel_on[LIMP_CH_B] == $past(input_pin_two))
    else $error("limp routing of second pin wrong");
  a_limp_others_off: assert property ( // R14
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP) |=> channel_on[LIMP_CH_A-1:0] == '0
      && channel_on[NCH-1:LIMP_CH_B+1] == '0)
    else $error("unrouted channel on in limp home");
  a_limp_entry: assert property ( // R8
    @(posedge sys_clk) disable iff (rst)
    (mode != ST_LIMP && limp_home_input) |=> sel == SEL_RESET
      && mode == ST_LIMP)
    else $error("limp entry did not reset");
  a_limp_frame: assert property ( // R9
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_LIMP) |-> frame.limp)
    else $error("limp bit not reported");
  a_sleep_chan_off: assert property ( // R16
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_SLEEP) |=> channel_on == '0)
    else $error("channel on while asleep");
  a_sleep_stays: assert property ( // R16
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_SLEEP && !limp_home_input && !cmd.valid)
      |=> mode == ST_SLEEP)
    else $error("sleep left without a command");
  a_err_read_clr: assert property ( // R19
    @(posedge sys_clk) disable iff (rst)
    (frame_read && !any_reset && !uv_reset
      && !(cmd_ok && cmd.op == CMD_SLEEP)) |=> !error_flag)
    else $error("error flag not cleared by read");
  a_sel_follow: assert property ( // R17
    @(posedge sys_clk) disable iff (rst)
    (mode == ST_RUN && !any_reset && sel[1:0] == SEL_PIN_ONE)
      |=> channel_on[0] == $past(input_pin_one))
    else $error("channel did not follow pin");
endmodule
`default_nettype wire

// ===== hdl/rsris_pkg.sv
// Purpose: Constants and types for the relay switch reset and input select
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes:   Supply comparator outputs arrive as plain synchronous inputs
// Functional notes
// R1: Any reset turns channels off, registers default
// R2: After any reset, set transmission error flag
// R3: Undervoltage reset: reads return error diagnostic frame
// R4: Hold undervoltage reset until all supplies good
// R5: Assert undervoltage reset within one microsecond
// R6: Reset command bit written one triggers reset
// R7: Reset command clears configuration and diagnosis
// R8: Limp home entry resets writable registers
// R9: Limp home keeps reads, reports limp status
// R10: Limp home ignores every command until exit
// R11: Per-channel selector: off, pin one, two, on
// R12: Unconnected input reads low, channel off
// R13: Host waits up to 200 us after wake
// R14: Limp high starts limp, wakes, routes channels four/five
// R15: Limp home exit always enters sleep
// R16: Sleep by commands only; entering resets banks
// R17: Followed pin high means on, low off
// R18: Selector encoding 00 off,01,10,11 on; default off
// R19: Error flag held until read by frame
`default_nettype none
package rsris_pkg;
  // ---------------------------------------------------------------------
  // Sizes and encodings
  // ---------------------------------------------------------------------
  localparam int NUM_CHANNELS = 8;
  localparam int SEL_W        = 2;
  localparam logic [1:0] SEL_OFF     = 2'h0;
  localparam logic [1:0] SEL_PIN_ONE = 2'h1;
  localparam logic [1:0] SEL_PIN_TWO = 2'h2;
  localparam logic [1:0] SEL_ON      = 2'h3;
  localparam logic [15:0] SEL_RESET  = 16'h0000;
  localparam int LIMP_CH_A = 4;
  localparam int LIMP_CH_B = 5;
  localparam logic [7:0] DIAG_RESET  = 8'h00;
  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int UV_DELAY_US     = 1;
  localparam int UV_DELAY_MAX_PS = UV_DELAY_US * 1000 * 1000;
  // Longest time: round down, at least one cycle
  localparam int UV_DELAY_CYC    = (UV_DELAY_MAX_PS / CLK_PERIOD_PS) < 1 ?
                                   1 : (UV_DELAY_MAX_PS / CLK_PERIOD_PS);
  localparam int WAKE_TIME_US    = 200;
  localparam int WAKE_CYC        = WAKE_TIME_US * 1000000 / CLK_PERIOD_PS;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE, CMD_WRITE_SEL, CMD_SLEEP, CMD_WAKE
  } rsris_cmd_type;
  typedef struct packed {
    logic          valid;
    rsris_cmd_type op;
    logic [15:0]   sel;
    logic          reset_bit;
  } rsris_cmd_req_type;
  typedef struct packed {
    logic       error_flag;
    logic       limp;
    logic       sleep;
    logic       uv_reset;
    logic [7:0] diag;
  } rsris_frame_type;
endpackage
`default_nettype wire

// ===== hdl/rsris_chan_mux.sv
// Purpose: One channel's drive choice from its two-bit selector
// Assumes: Input pins are already synchronous, pulled low when open
// Notes:   Purely combinational; the top registers the result
`default_nettype none
module rsris_chan_mux
  import rsris_pkg::*;
(
  input  wire logic [1:0] sel,
  input  wire logic       pin_one,
  input  wire logic       pin_two,
  output logic            drive
);
  // ---------------------------------------------------------------------
  // Selector decode
  // ---------------------------------------------------------------------
  // Open pin reads low, so a followed open pin switches off
  always_comb begin
    case (sel)
      SEL_OFF:     drive = 1'b0;      // R18
      SEL_PIN_ONE: drive = pin_one;   // R17 R12
      SEL_PIN_TWO: drive = pin_two;   // R17 R12
      SEL_ON:      drive = 1'b1;      // R11
      default:     drive = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/rsris_host_model.sv
// Purpose: Host controller model issuing commands and frame reads
// Assumes: Requests launch just after a rising sys_clk edge
// Notes:   Each request is a one-cycle pulse, taken on one edge
`default_nettype none
module rsris_host_model
  import rsris_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire rsris_frame_type frame,
  output rsris_cmd_req_type    cmd,
  output logic                 frame_read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd = '0;
    frame_read = 1'b0;
  end
  // One command pulse; sleep and wake only through commands
  task automatic send(input rsris_cmd_type op, input logic [15:0] sel,
                      input logic rbit);
    @(posedge sys_clk);
    cmd <= '{valid: 1'b1, op: op, sel: sel, reset_bit: rbit};
    @(posedge sys_clk);
    cmd <= '0;
  endtask
  // Sample the frame, then tell the block it was read
  task automatic read_frame(output rsris_frame_type got);
    @(posedge sys_clk);
    got = frame;
    frame_read <= 1'b1;
    @(posedge sys_clk);
    frame_read <= 1'b0;
  endtask
  // Wake, then wait out the wake-up time before any new request
  task automatic wake(input int cyc);
    send(CMD_WAKE, 16'h0000, 1'b0);
    repeat (cyc) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for reset sources and channel selection
// Assumes: 200 MHz clock, inputs driven by NBA on the rising edge
// Notes:   Wake count shortened so sleep scenarios stay brief
`default_nettype none
module tb;
  import rsris_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE_N = 10;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              vbb_good = 1'b1;
  logic              vdd_good = 1'b1;
  logic              limp_home_input = 1'b0;
  logic              input_pin_one = 1'b0;
  logic              input_pin_two = 1'b0;
  logic [7:0]        diag_events = 8'h00;
  rsris_cmd_req_type cmd;
  logic              frame_read;
  logic [7:0]        channel_on;
  logic [15:0]       channel_input_select;
  rsris_frame_type   frame;
  logic              device_ready;
  rsris_frame_type   f;
  int                fails = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                n;
  always #2.5 sys_clk = ~sys_clk;
  rsris_top #(.WAKE_CNT(WAKE_N)) dut (
    .sys_clk(sys_clk), .rst(rst), .vbb_good(vbb_good),
    .vdd_good(vdd_good), .limp_home_input(limp_home_input),
    .input_pin_one(input_pin_one), .input_pin_two(input_pin_two),
    .cmd(cmd), .frame_read(frame_read), .diag_events(diag_events),
    .channel_on(channel_on), .channel_input_select(channel_input_select),
    .frame(frame), .device_ready(device_ready));
  rsris_host_model host (
    .sys_clk(sys_clk), .frame(frame), .cmd(cmd), .frame_read(frame_read));
  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic pins(input logic a, b);
    @(posedge sys_clk);
    input_pin_one <= a;
    input_pin_two <= b;
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard: all scenarios need well under this many cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    tick(3);
    chk(16'(channel_on), 16'h0000, "chan after rst");
    chk(channel_input_select, SEL_RESET, "sel after rst");
    chk(16'(frame.error_flag), 16'h0001, "flag after rst");
    host.read_frame(f);
    tick(2);
    chk(16'(frame.error_flag), 16'h0000, "flag after read");
  endtask
  // Open pins read low, so a followed pin at 0 keeps the channel off
  task automatic t_select;
    host.send(CMD_WRITE_SEL, 16'h00E4, 1'b0);
    tick(2);
    chk(channel_input_select, 16'h00E4, "sel write");
    for (int p = 0; p < 4; p++) begin
      pins(p[0], p[1]);
      tick(3);
      chk(16'(channel_on), {12'h000, 1'b1, p[1], p[0], 1'b0}, "mux");
      chk(16'(channel_on[2:1]), 16'(p[1:0]), "pin level");
    end
    pins(1'b0, 1'b0);
    tick(3);
    chk(16'(channel_on), 16'h0008, "pins low");
  endtask
  task automatic t_reset_cmd;
    @(posedge sys_clk);
    diag_events <= 8'h05;
    @(posedge sys_clk);
    diag_events <= 8'h00;
    tick(3);
    chk(16'(frame.diag), 16'h0005, "diag sticky");
    host.send(CMD_NONE, 16'h0000, 1'b1);
    tick(2);
    chk(channel_input_select, SEL_RESET, "sel after cmd");
    chk(16'(channel_on), 16'h0000, "chan after cmd");
    chk(16'(frame.diag), 16'(DIAG_RESET), "diag after cmd");
    chk(16'(frame.error_flag), 16'h0001, "flag after cmd");
    host.read_frame(f);
  endtask
  task automatic t_uv;
    host.send(CMD_WRITE_SEL, 16'hC000, 1'b0);
    tick(2);
    @(posedge sys_clk);
    vdd_good <= 1'b0;
    for (n = 0; n < 210 && channel_on !== 8'h00; n++) tick(1);
    chk(16'(n <= 203), 16'h0001, "uv delay");
    chk(16'(frame.error_flag), 16'h0001, "uv flag");
    chk(16'(frame.uv_reset), 16'h0001, "uv status");
    host.send(CMD_WRITE_SEL, 16'hFFFF, 1'b0);
    host.read_frame(f);
    chk(16'(f.error_flag), 16'h0001, "uv read");
    tick(2);
    chk(16'(frame.error_flag), 16'h0001, "uv flag held");
    chk(channel_input_select, SEL_RESET, "uv refuses");
    @(posedge sys_clk);
    vbb_good <= 1'b0;
    vdd_good <= 1'b1;
    tick(6);
    chk(16'(device_ready), 16'h0000, "one supply low");
    @(posedge sys_clk);
    vbb_good <= 1'b1;
    tick(6);
    chk(16'(device_ready), 16'h0001, "supplies good");
    chk(16'(frame.uv_reset), 16'h0000, "uv released");
    host.read_frame(f);
  endtask
  task automatic t_limp;
    host.send(CMD_WRITE_SEL, 16'hFFFF, 1'b0);
    pins(1'b1, 1'b0);
    @(posedge sys_clk);
    limp_home_input <= 1'b1;
    tick(4);
    chk(channel_input_select, SEL_RESET, "limp sel");
    chk(16'(channel_on), 16'h0010, "limp routing");
    host.send(CMD_WRITE_SEL, 16'hFFFF, 1'b0);
    host.read_frame(f);
    chk(16'(f.limp), 16'h0001, "limp status");
    chk(channel_input_select, SEL_RESET, "limp refuses");
    pins(1'b0, 1'b1);
    tick(3);
    chk(16'(channel_on), 16'h0020, "limp pin two");
    @(posedge sys_clk);
    limp_home_input <= 1'b0;
    tick(4);
    chk(16'(frame.sleep), 16'h0001, "sleep after limp");
    host.wake(WAKE_N + 6);
    tick(1);
    chk(16'(device_ready), 16'h0001, "awake");
  endtask
  task automatic t_sleep;
    host.send(CMD_WRITE_SEL, 16'h0003, 1'b0);
    host.read_frame(f);
    host.send(CMD_SLEEP, 16'h0000, 1'b0);
    tick(2);
    chk(channel_input_select, SEL_RESET, "sleep resets");
    chk(16'(frame.error_flag), 16'h0001, "sleep flag");
    host.send(CMD_WRITE_SEL, 16'h0003, 1'b0);
    tick(2);
    chk(16'(channel_on), 16'h0000, "sleep refuses");
    chk(channel_input_select, SEL_RESET, "sleep keeps sel");
    // Limp input must wake the block out of sleep
    @(posedge sys_clk);
    limp_home_input <= 1'b1;
    tick(3);
    chk(16'(frame.limp), 16'h0001, "limp wakes");
    chk(16'(channel_on), 16'h0020, "limp from sleep");
    @(posedge sys_clk);
    limp_home_input <= 1'b0;
    tick(3);
    chk(16'(frame.sleep), 16'h0001, "back to sleep");
    host.wake(WAKE_N + 6);
    host.send(CMD_WRITE_SEL, 16'h0003, 1'b0);
    tick(2);
    chk(16'(channel_on), 16'h0001, "run again");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_select();
    t_reset_cmd();
    t_uv();
    t_limp();
    t_sleep();
    conclude();
  end
endmodule
`default_nettype wire
